/* File: hdl/tonnage_monitor.v */
// stroke tonnage signature monitor: nulling, acquisition, band compare, relays, counters
// assumes sensor words and crank angle synchronous to core_clk, one reading set per cycle
`timescale 1ns/1ps
`default_nettype none
`include "tonnage_monitor_regs.vh"
module tonnage_monitor #(
	parameter DW = 16,
	parameter NCH = `NUM_CHANNELS,
	parameter NPR = `NUM_PROFILES,
	parameter NB = `NUM_BINS,
	parameter CW = 24
) (
	input  wire            core_clk,
	input  wire            reset_n,
	input  wire [8:0]      crankAngle,
	input  wire [NCH*DW-1:0] sensorData,
	input  wire [NCH-1:0]  channelEnable,
	input  wire            programPermit,
	input  wire            supervisor1Permit,
	input  wire            supervisor2Permit,
	input  wire            faultClear,
	input  wire            cfgWrite,
	input  wire [2:0]      cfgSelect,
	input  wire [DW-1:0]   cfgValue,
	input  wire [2:0]      profileSelect,
	input  wire            learnMode,
	output wire            pressSafe,
	output wire            dieSafe,
	output wire            qualityAlarm,
	output wire [CW-1:0]   hitCount,
	output wire [CW-1:0]   goodCount,
	output wire [6:0]      goodPercent,
	output wire            cfgRefused
);
	// config select codes: 0 peak, 1 die band (sup2), 2 quality band (sup1), 3 learn strokes (sup2)
	localparam [2:0] SEL_PEAK = 3'h0;
	localparam [2:0] SEL_DIE = 3'h1;
	localparam [2:0] SEL_QUAL = 3'h2;
	localparam [2:0] SEL_LRN = 3'h3;
	reg        rstMeta_ff, rstSync_ff;
	wire       rstN = rstSync_ff;
	// reset release through two flops
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	reg [DW-1:0] peakLimit_ff, dieBand_ff, qualBand_ff;
	reg [3:0]    learnStrokes_ff;
	reg          cfgRefused_ff;
	// sup1 guards quality band, sup2 guards learn depth and die band
	wire levelOk = (cfgSelect == SEL_QUAL) ? supervisor1Permit :
		((cfgSelect == SEL_LRN) || (cfgSelect == SEL_DIE)) ? supervisor2Permit : 1'b1;
	wire cfgOk = programPermit && levelOk;
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			peakLimit_ff <= {DW{1'b1}};
			dieBand_ff <= {DW{1'b1}};
			qualBand_ff <= {DW{1'b1}};
			learnStrokes_ff <= 4'h4;
			cfgRefused_ff <= 1'b0;
		end else begin
			cfgRefused_ff <= cfgWrite && !cfgOk;
			if (cfgWrite && cfgOk) begin
				case (cfgSelect)
					SEL_PEAK: peakLimit_ff <= cfgValue;
					SEL_DIE: dieBand_ff <= cfgValue;
					SEL_QUAL: qualBand_ff <= cfgValue;
					SEL_LRN: learnStrokes_ff <= (cfgValue[3:0] == 4'h0) ? 4'h1 : cfgValue[3:0];
					default: ;
				endcase
			end
		end
	end

	// stroke sequencer on crank angle
	reg [2:0] state_ff, nxt_state;
	reg [8:0] prevAngle_ff;
	wire topCross = (crankAngle < prevAngle_ff); // wrap past 359
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`ST_IDLE: if (topCross) nxt_state = `ST_ZERO;
			`ST_ZERO: if (crankAngle >= `ANG_ZERO_END) nxt_state = `ST_ACQ;
			`ST_ACQ: if (crankAngle >= `ANG_ACQ_END) nxt_state = `ST_CMP;
			`ST_CMP: nxt_state = `ST_DONE;
			`ST_DONE: if (topCross) nxt_state = `ST_ZERO;
			default: nxt_state = `ST_IDLE;
		endcase
	end
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			state_ff <= `ST_IDLE;
			prevAngle_ff <= 9'h000;
		end else begin
			state_ff <= nxt_state;
			prevAngle_ff <= crankAngle;
		end
	end

	wire inWin = (state_ff == `ST_ACQ) && (crankAngle >= `ANG_ACQ_START) && (crankAngle < `ANG_ACQ_END);
	// offset into the window, cut on purpose to the four bin bits
	wire [8:0] winOffset = crankAngle - `ANG_ACQ_START;
	wire [3:0] bin = winOffset[`BIN_SHIFT+3:`BIN_SHIFT];
	wire [3:0] binOk = inWin ? bin : 4'h0;

	// learn session state, declared early because every channel slice reads it
	reg       learnActive_ff, firstLearn_ff;
	reg [3:0] learnLeft_ff;

	// per-channel nulling, acquisition, reference store and band checks
	wire [NCH-1:0] peakHit, dieOut, qualOut;
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : gCh
			wire [DW-1:0] raw = sensorData[c*DW +: DW];
			reg  [DW-1:0] zero_ff;
			wire [DW-1:0] net = (raw > zero_ff) ? raw - zero_ff : {DW{1'b0}};
			reg  [DW-1:0] cur_ff [0:NB-1];
			reg  [DW-1:0] ref_ff [0:NPR*NB-1];
			reg           dieBad_ff, qualBad_ff;
			// one loop index per process, so no index is shared between processes
			integer bz, bc, bl;
			// null offset at top, track running max per bin
			always @(posedge core_clk or negedge rstN) begin
				if (!rstN) begin
					zero_ff <= {DW{1'b0}};
					for (bz = 0; bz < NB; bz = bz + 1)
						cur_ff[bz] <= {DW{1'b0}};
				end else if (state_ff == `ST_ZERO) begin
					zero_ff <= raw;
					for (bz = 0; bz < NB; bz = bz + 1)
						cur_ff[bz] <= {DW{1'b0}};
				end else if (inWin && net > cur_ff[binOk]) begin
					cur_ff[binOk] <= net;
				end
			end
			// band check over all bins while comparing
			reg dieAny, qualAny;
			reg [DW:0] diff;
			always @* begin
				dieAny = 1'b0;
				qualAny = 1'b0;
				diff = {(DW+1){1'b0}};
				for (bc = 0; bc < NB; bc = bc + 1) begin
					diff = (cur_ff[bc] > ref_ff[profileSelect*NB+bc]) ?
						{1'b0, cur_ff[bc]} - {1'b0, ref_ff[profileSelect*NB+bc]} :
						{1'b0, ref_ff[profileSelect*NB+bc]} - {1'b0, cur_ff[bc]};
					if (diff > {1'b0, dieBand_ff}) dieAny = 1'b1;
					if (diff > {1'b0, qualBand_ff}) qualAny = 1'b1;
				end
			end
			// learn averages toward each stroke; plain copy on first stroke
			always @(posedge core_clk or negedge rstN) begin
				if (!rstN) begin
					for (bl = 0; bl < NPR*NB; bl = bl + 1)
						ref_ff[bl] <= {DW{1'b0}};
				end else if (state_ff == `ST_CMP && learnActive_ff) begin
					for (bl = 0; bl < NB; bl = bl + 1)
						ref_ff[profileSelect*NB+bl] <= firstLearn_ff ? cur_ff[bl] :
							ref_ff[profileSelect*NB+bl] - (ref_ff[profileSelect*NB+bl] >> `LEARN_SHIFT)
							+ (cur_ff[bl] >> `LEARN_SHIFT);
				end
			end
			assign peakHit[c] = channelEnable[c] && (net > peakLimit_ff);
			assign dieOut[c] = channelEnable[c] && dieAny;
			assign qualOut[c] = channelEnable[c] && qualAny;
		end
	endgenerate

	// learn session: counts down learn strokes, no judging while learning
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			learnActive_ff <= 1'b0;
			firstLearn_ff <= 1'b0;
			learnLeft_ff <= 4'h0;
		end else if (!learnActive_ff) begin
			if (learnMode && programPermit && state_ff == `ST_ZERO) begin
				learnActive_ff <= 1'b1;
				firstLearn_ff <= 1'b1;
				learnLeft_ff <= learnStrokes_ff;
			end
		end else if (state_ff == `ST_CMP) begin
			firstLearn_ff <= 1'b0;
			learnLeft_ff <= learnLeft_ff - 4'h1;
			if (learnLeft_ff == 4'h1 || !learnMode)
				learnActive_ff <= 1'b0;
		end
	end

	// relays and counters; fault latch set wins over clear
	reg pressOk_ff, dieOk_ff, qualAl_ff;
	reg [CW-1:0] hits_ff, good_ff;
	wire judge = (state_ff == `ST_CMP) && !learnActive_ff;
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pressOk_ff <= 1'b1;
			dieOk_ff <= 1'b1;
			qualAl_ff <= 1'b0;
			hits_ff <= {CW{1'b0}};
			good_ff <= {CW{1'b0}};
		end else begin
			if (|peakHit) pressOk_ff <= 1'b0;
			else if (faultClear) pressOk_ff <= 1'b1;
			if (judge && |dieOut) dieOk_ff <= 1'b0;
			else if (faultClear) dieOk_ff <= 1'b1;
			if (judge) qualAl_ff <= |qualOut;
			if (state_ff == `ST_CMP) begin
				hits_ff <= hits_ff + 1'b1;
				if (judge && !(|qualOut)) good_ff <= good_ff + 1'b1;
			end
		end
	end

	// percentage by repeated division is too slow; a coarse sequential divider instead
	reg [6:0]  pct_ff;
	reg [CW+6:0] acc_ff;
	reg [6:0]  q_ff;
	reg        pctLoad_ff;
	// load one cycle after compare, so numerator and denominator are both this stroke's counts
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pct_ff <= 7'h00;
			acc_ff <= {(CW+7){1'b0}};
			q_ff <= 7'h00;
			pctLoad_ff <= 1'b0;
		end else begin
			pctLoad_ff <= (state_ff == `ST_CMP);
			if (pctLoad_ff) begin
				acc_ff <= good_ff * 7'h64;
				q_ff <= 7'h00;
			end else if (hits_ff != {CW{1'b0}} && acc_ff >= {7'h00, hits_ff} && q_ff < 7'h64) begin
				acc_ff <= acc_ff - {7'h00, hits_ff};
				q_ff <= q_ff + 7'h01;
			end else begin
				pct_ff <= q_ff;
			end
		end
	end

	assign pressSafe = pressOk_ff;
	assign dieSafe = dieOk_ff;
	assign qualityAlarm = qualAl_ff;
	assign hitCount = hits_ff;
	assign goodCount = good_ff;
	assign goodPercent = pct_ff;
	assign cfgRefused = cfgRefused_ff;
endmodule // tonnage_monitor
`default_nettype wire

/* File: hdl/tonnage_monitor_regs.vh */
// constants for the stroke tonnage signature monitor
// assumes crank angle in whole degrees 0..359 from the resolver decoder
`ifndef TONNAGE_MONITOR_REGS_VH
`define TONNAGE_MONITOR_REGS_VH
`define ANG_ZERO_END   9'h00A
`define ANG_ACQ_START  9'h03C
`define ANG_ACQ_END    9'h0F0
`define ANG_LAST       9'h167
`define NUM_CHANNELS   8
`define NUM_PROFILES   8
`define NUM_BINS       16
`define BIN_SHIFT      4
`define LEARN_SHIFT    2
`define ST_IDLE        3'h0
`define ST_ZERO        3'h1
`define ST_ACQ         3'h2
`define ST_CMP         3'h3
`define ST_DONE        3'h4
`endif

/* File: tb/press_sensor_model.sv */
// press side: resolver angle and eight strain-gauge tonnage channels
// assumes one degree per core_clk while run is high
`timescale 1ns/1ps
`default_nettype none
module press_sensor_model (
	input  wire logic         core_clk,
	input  wire logic         run,
	input  wire logic [15:0]  load,
	output var  logic [8:0]   crankAngle,
	output var  logic [127:0] sensorData
);
	localparam logic [15:0] DRIFT = 16'h01F4; // offset the monitor must null
	// angle parked at top while stopped; wraps 359 to 0, so one stroke lasts 360 cycles
	always @(posedge core_clk) begin
		if (!run)
			crankAngle <= 9'h000;
		else
			crankAngle <= (crankAngle == 9'h167) ? 9'h000 : crankAngle + 9'h001;
	end
	// load only in the working window, drift always present
	always @* begin
		sensorData = {8{DRIFT + ((crankAngle >= 9'h03C && crankAngle < 9'h0F0) ? load : 16'h0000)}};
	end
endmodule // press_sensor_model
`default_nettype wire

/* File: tb/tonnage_monitor_checker.sv */
// assertions on relays, counters and setting refusal
// assumes bind onto tonnage_monitor, single clock domain
`timescale 1ns/1ps
`default_nettype none
module tonnage_monitor_checker #(parameter CW = 24) (
	input wire logic          core_clk,
	input wire logic          reset_n,
	input wire logic [8:0]    crankAngle,
	input wire logic          programPermit,
	input wire logic          faultClear,
	input wire logic          cfgWrite,
	input wire logic          cfgRefused,
	input wire logic          pressSafe,
	input wire logic          dieSafe,
	input wire logic [CW-1:0] hitCount,
	input wire logic [CW-1:0] goodCount,
	input wire logic [6:0]    goodPercent
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// write attempt without permit, then its refusal pulse
	sequence sBadWr; cfgWrite && !programPermit; endsequence
	sequence sRefuse; cfgRefused; endsequence
	AST_REFUSE: assert property (sBadWr |=> sRefuse)
		else $error("refused write gave no pulse");
	AST_PRESS_HOLD: assert property (!pressSafe && !faultClear |=> !pressSafe)
		else $error("press relay came back without clear");
	AST_DIE_HOLD: assert property (!dieSafe && !faultClear |=> !dieSafe)
		else $error("die relay came back without clear");
	AST_PRESS_REL: assert property ($rose(pressSafe) |-> $past(faultClear))
		else $error("press relay rose with no clear");
	AST_DIE_REL: assert property ($rose(dieSafe) |-> $past(faultClear))
		else $error("die relay rose with no clear");
	AST_HIT_STEP: assert property ($changed(hitCount) |-> hitCount == $past(hitCount) + 1'b1)
		else $error("hit count jumped");
	AST_HIT_ANGLE: assert property ($changed(hitCount) |-> crankAngle >= 9'h0F0)
		else $error("hit counted outside compare span");
	AST_GOOD_LE: assert property (goodCount <= hitCount)
		else $error("good parts above hits");
	AST_PCT: assert property (goodPercent <= 7'h64)
		else $error("percentage above hundred");
endmodule // tonnage_monitor_checker
bind tonnage_monitor tonnage_monitor_checker #(.CW(CW)) chk (.core_clk(core_clk), .reset_n(reset_n),
	.crankAngle(crankAngle), .programPermit(programPermit), .faultClear(faultClear), .cfgWrite(cfgWrite),
	.cfgRefused(cfgRefused), .pressSafe(pressSafe), .dieSafe(dieSafe), .hitCount(hitCount),
	.goodCount(goodCount), .goodPercent(goodPercent));
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the tonnage monitor
// assumes press_sensor_model on the sensor side, 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic         core_clk, reset_n, run, programPermit, sup1, sup2, faultClear, cfgWrite, learnMode;
	logic         pressSafe, dieSafe, qualityAlarm, cfgRefused;
	logic [2:0]   cfgSelect, prof;
	logic [15:0]  cfgValue, load;
	logic [8:0]   crankAngle;
	logic [127:0] sensorData;
	logic [23:0]  hitCount, goodCount;
	logic [6:0]   goodPercent;
	int           err_total = 0, n_compared = 0;
	press_sensor_model model (.core_clk(core_clk), .run(run), .load(load), .crankAngle(crankAngle),
		.sensorData(sensorData));
	tonnage_monitor dut (.core_clk(core_clk), .reset_n(reset_n), .crankAngle(crankAngle),
		.sensorData(sensorData), .channelEnable(8'hFF), .programPermit(programPermit),
		.supervisor1Permit(sup1), .supervisor2Permit(sup2), .faultClear(faultClear), .cfgWrite(cfgWrite),
		.cfgSelect(cfgSelect), .cfgValue(cfgValue), .profileSelect(prof), .learnMode(learnMode),
		.pressSafe(pressSafe), .dieSafe(dieSafe), .qualityAlarm(qualityAlarm), .hitCount(hitCount),
		.goodCount(goodCount), .goodPercent(goodPercent), .cfgRefused(cfgRefused));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [2:0] sel, input logic [15:0] val, input logic pp, s1, s2, expRef);
		@(posedge core_clk);
		{cfgWrite, cfgSelect, cfgValue, programPermit, sup1, sup2} <= {1'b1, sel, val, pp, s1, s2};
		@(posedge core_clk) cfgWrite <= 1'b0;
		#1 check(cfgRefused, expRef);
	endtask
	// one whole stroke at the given load, ends at angle 359
	task automatic stroke(input logic [15:0] l);
		int i;
		for (i = 0; i < 400 && crankAngle !== 9'h167; i++) @(negedge core_clk);
		@(posedge core_clk) load <= l;
		@(negedge core_clk);
		for (i = 0; i < 400 && crankAngle !== 9'h167; i++) @(negedge core_clk);
	endtask
	task automatic clr;
		@(posedge core_clk) faultClear <= 1'b1;
		@(posedge core_clk);
		@(posedge core_clk) faultClear <= 1'b0;
		@(negedge core_clk);
		check({pressSafe, dieSafe}, 2'h3);
	endtask
	task automatic tReset;
		@(negedge core_clk);
		check({pressSafe, dieSafe, qualityAlarm}, 3'h6);
		check(hitCount, 24'h000000);
	endtask
	// refusals by permit level, each followed by the real setting
	task automatic tConfig;
		wr(3'h0, 16'h0258, 1'b0, 1'b0, 1'b0, 1'b1);
		wr(3'h0, 16'h0258, 1'b1, 1'b0, 1'b0, 1'b0);
		wr(3'h2, 16'h0014, 1'b1, 1'b0, 1'b1, 1'b1);
		wr(3'h2, 16'h0014, 1'b1, 1'b1, 1'b0, 1'b0);
		wr(3'h1, 16'h0032, 1'b1, 1'b1, 1'b0, 1'b1);
		wr(3'h1, 16'h0032, 1'b1, 1'b0, 1'b1, 1'b0);
		wr(3'h3, 16'h0001, 1'b1, 1'b0, 1'b1, 1'b0);
	endtask
	task automatic tLearn;
		@(posedge core_clk) learnMode <= 1'b1;
		stroke(16'h00C8);
		check({hitCount, goodCount}, {24'h000001, 24'h000000});
		@(posedge core_clk) learnMode <= 1'b0;
	endtask
	// raw reading tops the peak limit, net does not
	task automatic tGood;
		stroke(16'h00C8);
		check({pressSafe, dieSafe, qualityAlarm}, 3'h6);
		check({hitCount, goodCount}, {24'h000002, 24'h000001});
		check(goodPercent, 7'h32);
	endtask
	task automatic tQuality;
		stroke(16'h00E6);
		check({dieSafe, qualityAlarm}, 2'h3);
		check(goodCount, 24'h000001);
	endtask
	task automatic tDie;
		stroke(16'h012C);
		check({pressSafe, dieSafe}, 2'h2);
		stroke(16'h00C8);
		check({dieSafe, qualityAlarm}, 2'h0);
		clr;
	endtask
	task automatic tPeak;
		stroke(16'h0320);
		check(pressSafe, 1'b0);
		clr;
		check(hitCount, 24'h000007);
	endtask
	// unlearned slot five judges against zero, slot two keeps its learned reference
	task automatic tProfile;
		@(posedge core_clk) prof <= 3'h5;
		stroke(16'h00C8);
		check(qualityAlarm, 1'b1);
		@(posedge core_clk) prof <= 3'h2;
		stroke(16'h00C8);
		check(qualityAlarm, 1'b0);
	endtask
	initial begin
		{reset_n, run, programPermit, sup1, sup2, faultClear, cfgWrite, learnMode} = 8'h00;
		{cfgSelect, cfgValue, load} = 35'h0;
		prof = 3'h2;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		tReset;
		tConfig;
		@(posedge core_clk) run <= 1'b1;
		tLearn;
		tGood;
		tQuality;
		tDie;
		tPeak;
		tProfile;
		conclude;
	end
	// about 4,000 cycles expected, cut off at 20,000
	initial begin
		#200000;
		err_total++;
		conclude;
	end
endmodule // tb_top
`default_nettype wire
